// ==== rtl/scpm_pkg.sv ====
// Constants and types of the strap capture and pin mux block
`default_nettype none
package scpm_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GPIO_OE = 8'h04;
  localparam logic [7:0] ADDR_GPIO_OUT = 8'h08;
  localparam logic [7:0] ADDR_GPIO_IN = 8'h0c;
  localparam logic [7:0] ADDR_STRAP = 8'h10;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam int CTRL_CH0_LSB = 0;
  localparam int CTRL_CH1_LSB = 4;
  localparam int INT_WAKE_BIT = 0;
  localparam int INT_STRAP_BIT = 1;
  localparam logic [3:0] TX_CURRENT_RST = 4'h0;
  localparam logic [3:0] TX_EQ_RST = 4'h8;
  localparam logic [1:0] TERM_RST = 2'h0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] GPIO_OE_RST = 8'h00;
  localparam logic [7:0] GPIO_OUT_RST = 8'h00;
  localparam logic [1:0] INT_RST = 2'h0;
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } scpm_state_type;
endpackage : scpm_pkg
`default_nettype wire

// ==== rtl/scpm_top.sv ====
// Strap capture, shared pin mux, wake output and APB register slave
`timescale 1ns/10ps
`default_nettype none
module scpm_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // System reset, strap window
  input wire logic system_reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel-0 mode pins
  input wire logic [3:0] ch0XcvrModeSelIn,
  output logic [3:0] ch0XcvrModeSel,
  output logic [3:0] ch0XcvrModeSelOe,
  // Channel-1 mode pins
  input wire logic [3:0] ch1XcvrModeSelIn,
  output logic [3:0] ch1XcvrModeSel,
  output logic [3:0] ch1XcvrModeSelOe,
  // General-purpose pins
  input wire logic [7:0] gpioIn,
  output logic [7:0] gpioOut,
  output logic [7:0] gpioOe,
  // Wake path
  input wire logic ringInd0_n,
  input wire logic linkInL2,
  output logic wakeup_n,
  // Captured straps
  output logic [3:0] txCurrentLevel,
  output logic driveReduceFlag,
  output logic phyDebugSelect,
  output logic driveBoostFlag,
  output logic [3:0] txEqualizationLevel,
  output logic eepromWordOrg,
  output logic [1:0] rxTerminationAdjust,
  output logic [1:0] txTerminationAdjust,
  output logic strapValid,
  // Interrupt
  output logic irq
);
  import scpm_pkg::*;

  // State
  scpm_state_type state_q;
  scpm_state_type state_d;

  // Strap registers
  logic [3:0] txCur_q;
  logic [3:0] txCur_d;
  logic reduce_q;
  logic reduce_d;
  logic debug_q;
  logic debug_d;
  logic boost_q;
  logic boost_d;
  logic [3:0] txEq_q;
  logic [3:0] txEq_d;
  logic org_q;
  logic org_d;
  logic [1:0] rxTerm_q;
  logic [1:0] rxTerm_d;
  logic [1:0] txTerm_q;
  logic [1:0] txTerm_d;

  // Software registers
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] gpioOeReg_q;
  logic [7:0] gpioOeReg_d;
  logic [7:0] gpioOutReg_q;
  logic [7:0] gpioOutReg_d;
  logic [1:0] intStatus_q;
  logic [1:0] intStatus_d;
  logic [1:0] intMask_q;
  logic [1:0] intMask_d;

  // Pin drive registers
  logic [3:0] ch0Out_q;
  logic [3:0] ch0Out_d;
  logic [3:0] ch0Oe_q;
  logic [3:0] ch0Oe_d;
  logic [3:0] ch1Out_q;
  logic [3:0] ch1Out_d;
  logic [3:0] ch1Oe_q;
  logic [3:0] ch1Oe_d;
  logic [7:0] gpioPinOut_q;
  logic [7:0] gpioPinOut_d;
  logic [7:0] gpioPinOe_q;
  logic [7:0] gpioPinOe_d;
  logic wake_n_q;
  logic wake_n_d;
  logic irq_q;
  logic irq_d;

  // APB answer registers
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  // Decode helpers
  logic accessFirst;
  logic writeCommit;
  logic addrHit;
  logic wakeEvent;
  logic strapEvent;
  logic [1:0] eventSet;

  // Strap window sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SAMPLE: begin
        if (system_reset_n) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_d = system_reset_n ? ST_RUN : ST_SAMPLE;
      end
      ST_RUN: begin
        if (!system_reset_n) begin
          state_d = ST_SAMPLE;
        end
      end
      default: begin
        state_d = ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_SAMPLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Strap capture, follows pins only while system reset is low
  always_comb begin
    txCur_d = txCur_q;
    reduce_d = reduce_q;
    debug_d = debug_q;
    boost_d = boost_q;
    txEq_d = txEq_q;
    org_d = org_q;
    rxTerm_d = rxTerm_q;
    txTerm_d = txTerm_q;
    if (state_q == ST_SAMPLE && !system_reset_n) begin
      txCur_d = {ch1XcvrModeSelIn[2:0], ch0XcvrModeSelIn[3]};
      reduce_d = ch0XcvrModeSelIn[2];
      debug_d = ch0XcvrModeSelIn[1];
      boost_d = ch0XcvrModeSelIn[0];
      txEq_d = {gpioIn[2:0], ch1XcvrModeSelIn[3]};
      org_d = gpioIn[7];
      rxTerm_d = gpioIn[6:5];
      txTerm_d = gpioIn[4:3];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txCur_q <= TX_CURRENT_RST;
      reduce_q <= 1'b0;
      debug_q <= 1'b0;
      boost_q <= 1'b0;
      txEq_q <= TX_EQ_RST;
      org_q <= 1'b0;
      rxTerm_q <= TERM_RST;
      txTerm_q <= TERM_RST;
    end else begin
      txCur_q <= txCur_d;
      reduce_q <= reduce_d;
      debug_q <= debug_d;
      boost_q <= boost_d;
      txEq_q <= txEq_d;
      org_q <= org_d;
      rxTerm_q <= rxTerm_d;
      txTerm_q <= txTerm_d;
    end
  end

  // APB decode
  always_comb begin
    accessFirst = psel && penable && !pready_q;
    writeCommit = psel && penable && pready_q && pwrite;
    case (paddr)
      ADDR_CTRL, ADDR_GPIO_OE, ADDR_GPIO_OUT, ADDR_GPIO_IN,
      ADDR_STRAP, ADDR_INT_STATUS, ADDR_INT_MASK, ADDR_STATUS: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  // Events and software registers
  always_comb begin
    wakeEvent = wake_n_q && !wake_n_d;
    strapEvent = (state_q == ST_HOLD) && (state_d == ST_RUN);
    eventSet = 2'h0;
    eventSet[INT_WAKE_BIT] = wakeEvent;
    eventSet[INT_STRAP_BIT] = strapEvent;
    ctrl_d = ctrl_q;
    gpioOeReg_d = gpioOeReg_q;
    gpioOutReg_d = gpioOutReg_q;
    intMask_d = intMask_q;
    intStatus_d = intStatus_q;
    if (writeCommit) begin
      case (paddr)
        ADDR_CTRL: ctrl_d = pwdata[7:0];
        ADDR_GPIO_OE: gpioOeReg_d = pwdata[7:0];
        ADDR_GPIO_OUT: gpioOutReg_d = pwdata[7:0];
        ADDR_INT_STATUS: intStatus_d = intStatus_q & ~pwdata[1:0];
        ADDR_INT_MASK: intMask_d = pwdata[1:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    intStatus_d = intStatus_d | eventSet;
    irq_d = |(intStatus_d & intMask_d);
  end

  // Pin drive, released only after straps are held
  always_comb begin
    ch0Out_d = ctrl_d[CTRL_CH0_LSB +: 4];
    ch1Out_d = ctrl_d[CTRL_CH1_LSB +: 4];
    gpioPinOut_d = gpioOutReg_d;
    if (state_d == ST_RUN) begin
      ch0Oe_d = 4'hf;
      ch1Oe_d = 4'hf;
      gpioPinOe_d = gpioOeReg_d;
    end else begin
      ch0Oe_d = 4'h0;
      ch1Oe_d = 4'h0;
      gpioPinOe_d = 8'h00;
    end
  end

  // Wake output, held until the link leaves L2
  always_comb begin
    wake_n_d = wake_n_q;
    if (state_q != ST_RUN || !linkInL2) begin
      wake_n_d = 1'b1;
    end else if (!ringInd0_n) begin
      wake_n_d = 1'b0;
    end
  end

  // APB read answer, one wait state
  always_comb begin
    pready_d = accessFirst;
    pslverr_d = accessFirst && !addrHit;
    prdata_d = prdata_q;
    if (accessFirst) begin
      prdata_d = 32'h0;
      if (!pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata_d[7:0] = ctrl_q;
          ADDR_GPIO_OE: prdata_d[7:0] = gpioOeReg_q;
          ADDR_GPIO_OUT: prdata_d[7:0] = gpioOutReg_q;
          ADDR_GPIO_IN: prdata_d[7:0] = gpioIn;
          ADDR_STRAP: prdata_d[16:0] = {strapValid, txTerm_q, rxTerm_q, org_q,
                                        txEq_q, debug_q, boost_q, reduce_q, txCur_q};
          ADDR_INT_STATUS: prdata_d[1:0] = intStatus_q;
          ADDR_INT_MASK: prdata_d[1:0] = intMask_q;
          ADDR_STATUS: prdata_d[3:0] = {state_q, wake_n_q};
          default: prdata_d = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RST;
      gpioOeReg_q <= GPIO_OE_RST;
      gpioOutReg_q <= GPIO_OUT_RST;
      intStatus_q <= INT_RST;
      intMask_q <= INT_RST;
      irq_q <= 1'b0;
      ch0Out_q <= 4'h0;
      ch0Oe_q <= 4'h0;
      ch1Out_q <= 4'h0;
      ch1Oe_q <= 4'h0;
      gpioPinOut_q <= 8'h00;
      gpioPinOe_q <= 8'h00;
      wake_n_q <= 1'b1;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      gpioOeReg_q <= gpioOeReg_d;
      gpioOutReg_q <= gpioOutReg_d;
      intStatus_q <= intStatus_d;
      intMask_q <= intMask_d;
      irq_q <= irq_d;
      ch0Out_q <= ch0Out_d;
      ch0Oe_q <= ch0Oe_d;
      ch1Out_q <= ch1Out_d;
      ch1Oe_q <= ch1Oe_d;
      gpioPinOut_q <= gpioPinOut_d;
      gpioPinOe_q <= gpioPinOe_d;
      wake_n_q <= wake_n_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ch0XcvrModeSel = ch0Out_q;
  assign ch0XcvrModeSelOe = ch0Oe_q;
  assign ch1XcvrModeSel = ch1Out_q;
  assign ch1XcvrModeSelOe = ch1Oe_q;
  assign gpioOut = gpioPinOut_q;
  assign gpioOe = gpioPinOe_q;
  assign wakeup_n = wake_n_q;
  assign txCurrentLevel = txCur_q;
  assign driveReduceFlag = reduce_q;
  assign phyDebugSelect = debug_q;
  assign driveBoostFlag = boost_q;
  assign txEqualizationLevel = txEq_q;
  assign eepromWordOrg = org_q;
  assign rxTerminationAdjust = rxTerm_q;
  assign txTerminationAdjust = txTerm_q;
  assign strapValid = state_q[2];
  assign irq = irq_q;
endmodule : scpm_top
`default_nettype wire

// ==== sim/scpm_board.sv ====
// Board strap resistors and transceiver pin levels
`timescale 1ns/10ps
`default_nettype none
module scpm_board (
  // Design side
  input wire logic [3:0] ch0Drv,
  input wire logic [3:0] ch0Oe,
  input wire logic [3:0] ch1Drv,
  input wire logic [3:0] ch1Oe,
  input wire logic [7:0] gpioDrv,
  input wire logic [7:0] gpioOe,
  // Resistor levels
  input wire logic [3:0] strap0,
  input wire logic [3:0] strap1,
  input wire logic [7:0] strapG,
  // Pin levels
  output logic [3:0] ch0Pin,
  output logic [3:0] ch1Pin,
  output logic [7:0] gpioPin
);
  // Driven bit wins, else resistor level; debug strap low unless a test sets it
  assign ch0Pin = (ch0Oe & ch0Drv) | (~ch0Oe & strap0);
  assign ch1Pin = (ch1Oe & ch1Drv) | (~ch1Oe & strap1);
  assign gpioPin = (gpioOe & gpioDrv) | (~gpioOe & strapG);
endmodule : scpm_board
`default_nettype wire

// ==== sim/scpm_checker.sv ====
// Assertions on the strap capture and pin mux ports
`timescale 1ns/10ps
`default_nettype none
module scpm_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic system_reset_n,
  // Pins
  input wire logic [3:0] ch0XcvrModeSelIn,
  input wire logic [3:0] ch0XcvrModeSelOe,
  input wire logic [3:0] ch1XcvrModeSelIn,
  input wire logic [3:0] ch1XcvrModeSelOe,
  input wire logic [7:0] gpioIn,
  input wire logic [7:0] gpioOe,
  // Wake
  input wire logic ringInd0_n,
  input wire logic linkInL2,
  input wire logic wakeup_n,
  // Straps
  input wire logic [3:0] txCurrentLevel,
  input wire logic driveReduceFlag,
  input wire logic phyDebugSelect,
  input wire logic driveBoostFlag,
  input wire logic [3:0] txEqualizationLevel,
  input wire logic eepromWordOrg,
  input wire logic [1:0] rxTerminationAdjust,
  input wire logic [1:0] txTerminationAdjust,
  input wire logic strapValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] pins;
  logic [15:0] straps;
  assign pins = {gpioIn, ch1XcvrModeSelIn, ch0XcvrModeSelIn};
  assign straps = {eepromWordOrg, rxTerminationAdjust, txTerminationAdjust, txEqualizationLevel, txCurrentLevel,
                   driveReduceFlag, phyDebugSelect, driveBoostFlag};
  sequence s_win;
    !system_reset_n && !$past(system_reset_n);
  endsequence
  property p_undriven; !strapValid |-> !(|{ch0XcvrModeSelOe, ch1XcvrModeSelOe, gpioOe}); endproperty
  a_undriven: assert property (p_undriven) else $error("pin driven outside run");
  property p_cur; s_win |=> straps[6:3] == $past(pins[6:3]); endproperty
  a_cur: assert property (p_cur) else $error("current level capture");
  property p_flags; s_win |=> straps[2:0] == $past(pins[2:0]); endproperty
  a_flags: assert property (p_flags) else $error("drive flag capture");
  property p_gpio; s_win |=> straps[15:7] == $past(pins[15:7]); endproperty
  a_gpio: assert property (p_gpio) else $error("gpio strap capture");
  property p_freeze; system_reset_n |=> $stable(straps); endproperty
  a_freeze: assert property (p_freeze) else $error("straps moved");
  property p_release; $rose(system_reset_n) |=> !strapValid ##1 (!$past(system_reset_n) || strapValid); endproperty
  a_release: assert property (p_release) else $error("release timing");
  property p_wake; strapValid && linkInL2 && !ringInd0_n |=> !wakeup_n; endproperty
  a_wake: assert property (p_wake) else $error("wake missing");
  property p_wake_exit; !linkInL2 |=> wakeup_n; endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("wake outside L2");
  cover property ($fell(wakeup_n));
  cover property ($rose(strapValid));
  cover property (|gpioOe);
endmodule : scpm_checker
bind scpm_top scpm_checker i_chk (.clk(clk), .arst_n(arst_n), .system_reset_n(system_reset_n),
  .ch0XcvrModeSelIn(ch0XcvrModeSelIn), .ch0XcvrModeSelOe(ch0XcvrModeSelOe), .ch1XcvrModeSelIn(ch1XcvrModeSelIn),
  .ch1XcvrModeSelOe(ch1XcvrModeSelOe), .gpioIn(gpioIn), .gpioOe(gpioOe), .ringInd0_n(ringInd0_n),
  .linkInL2(linkInL2), .wakeup_n(wakeup_n), .txCurrentLevel(txCurrentLevel), .driveReduceFlag(driveReduceFlag),
  .phyDebugSelect(phyDebugSelect), .driveBoostFlag(driveBoostFlag), .txEqualizationLevel(txEqualizationLevel),
  .eepromWordOrg(eepromWordOrg), .rxTerminationAdjust(rxTerminationAdjust),
  .txTerminationAdjust(txTerminationAdjust), .strapValid(strapValid));
`default_nettype wire

// ==== sim/scpm_tb_top.sv ====
// Testbench for the strap capture and pin mux block
`timescale 1ns/10ps
`default_nettype none
module scpm_tb_top;
  import scpm_pkg::*;
  typedef struct {logic [3:0] s0, s1; logic [7:0] sg; logic [3:0] cur, eq;} scpm_row_type;
  logic clk, arst_n, system_reset_n, psel, penable, pwrite, pready, pslverr, ringInd0_n, linkInL2, wakeup_n;
  logic driveReduceFlag, phyDebugSelect, driveBoostFlag, eepromWordOrg, strapValid, irq, err;
  logic [7:0] paddr, gpioIn, gpioOut, gpioOe, strapG;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ch0XcvrModeSelIn, ch0XcvrModeSel, ch0XcvrModeSelOe, ch1XcvrModeSelIn, ch1XcvrModeSel;
  logic [3:0] ch1XcvrModeSelOe, txCurrentLevel, txEqualizationLevel, strap0, strap1;
  logic [1:0] rxTerminationAdjust, txTerminationAdjust;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  scpm_row_type rows[3] = '{'{4'h0, 4'h0, 8'h04, 4'h0, 4'h8}, '{4'hd, 4'ha, 8'hb3, 4'h5, 4'h7},
                            '{4'h2, 4'h7, 8'h4c, 4'he, 4'h8}};
  scpm_top i_dut (.clk(clk), .arst_n(arst_n), .system_reset_n(system_reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch0XcvrModeSelIn(ch0XcvrModeSelIn), .ch0XcvrModeSel(ch0XcvrModeSel), .ch0XcvrModeSelOe(ch0XcvrModeSelOe),
    .ch1XcvrModeSelIn(ch1XcvrModeSelIn), .ch1XcvrModeSel(ch1XcvrModeSel), .ch1XcvrModeSelOe(ch1XcvrModeSelOe),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .ringInd0_n(ringInd0_n), .linkInL2(linkInL2),
    .wakeup_n(wakeup_n), .txCurrentLevel(txCurrentLevel), .driveReduceFlag(driveReduceFlag),
    .phyDebugSelect(phyDebugSelect), .driveBoostFlag(driveBoostFlag), .txEqualizationLevel(txEqualizationLevel),
    .eepromWordOrg(eepromWordOrg), .rxTerminationAdjust(rxTerminationAdjust),
    .txTerminationAdjust(txTerminationAdjust), .strapValid(strapValid), .irq(irq));
  scpm_board i_board (.ch0Drv(ch0XcvrModeSel), .ch0Oe(ch0XcvrModeSelOe), .ch1Drv(ch1XcvrModeSel),
    .ch1Oe(ch1XcvrModeSelOe), .gpioDrv(gpioOut), .gpioOe(gpioOe), .strap0(strap0), .strap1(strap1),
    .strapG(strapG), .ch0Pin(ch0XcvrModeSelIn), .ch1Pin(ch1XcvrModeSelIn), .gpioPin(gpioIn));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m = "compare");
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic window(input scpm_row_type r);
    system_reset_n <= 1'b0;
    strap0 <= r.s0;
    strap1 <= r.s1;
    strapG <= r.sg;
    repeat (3) @(posedge clk);
    system_reset_n <= 1'b1;
    strapG <= ~r.sg;
    repeat (3) @(posedge clk);
  endtask : window
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    {arst_n, system_reset_n, psel, penable, pwrite, linkInL2} = '0;
    {paddr, pwdata, strap0, strap1} = '0;
    strapG = 8'h04;
    ringInd0_n = 1'b1;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk({txCurrentLevel, txEqualizationLevel, strapValid, wakeup_n, irq, gpioOe}, 19'h04200);
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clk);
      window(rows[i]);
      @(negedge clk);
      chk(txCurrentLevel, rows[i].cur);
      chk(txEqualizationLevel, rows[i].eq);
      chk({driveReduceFlag, phyDebugSelect, driveBoostFlag}, rows[i].s0[2:0]);
      chk({eepromWordOrg, rxTerminationAdjust, txTerminationAdjust}, rows[i].sg[7:3]);
      chk({strapValid, ch1XcvrModeSelOe, ch0XcvrModeSelOe}, 9'h1ff);
      $display("strap row %0d done", i);
    end
    apb(1'b1, ADDR_CTRL, 32'h5a);
    apb(1'b1, ADDR_GPIO_OE, 32'h0f);
    apb(1'b1, ADDR_GPIO_OUT, 32'h3c);
    apb(1'b0, ADDR_GPIO_IN, 32'h0);
    chk(rd, 32'hbc);
    chk(gpioOut, 8'h3c);
    @(negedge clk);
    chk({ch1XcvrModeSel, ch0XcvrModeSel, ch1XcvrModeSelIn, ch0XcvrModeSelIn}, 16'h5a5a);
    chk(gpioOe, 8'h0f);
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("register test done");
    @(posedge clk);
    linkInL2 <= 1'b1;
    ringInd0_n <= 1'b0;
    @(posedge clk);
    ringInd0_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk({wakeup_n, irq}, 2'b00);
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    linkInL2 <= 1'b0;
    apb(1'b1, ADDR_INT_STATUS, 32'h1);
    repeat (2) @(negedge clk);
    chk({wakeup_n, irq}, 2'b10);
    $display("wake test done");
    complete_run();
  end
endmodule : scpm_tb_top
`default_nettype wire
